// ===== design/rail_ctrl_defines.svh
/*
 * offsets, field positions, reset values and write masks of the rail control
 * registers. assumes inclusion by every file that uses the macros; the
 * guard keeps repeated inclusion harmless.
 */
`ifndef RAIL_CTRL_DEFINES_SVH
`define RAIL_CTRL_DEFINES_SVH

`define ADDR_CONVERTER_A_CONTROL   8'h26
`define ADDR_CONVERTER_B_CONTROL   8'h27
`define ADDR_LINEAR_REG_A_CONTROL  8'h28

`define FLD_SLEEP_SEL_HI           5
`define FLD_SLEEP_SEL_LO           4
`define FLD_OP_MODE                1
`define FLD_RAIL_ON                0

`define SLEEP_SEL_NORMAL           2'h0
`define SLEEP_SEL_PIN              2'h3

`define CONVERTER_RESET            8'h0C
`define LINEAR_RESET               8'h0C

`define CONVERTER_RW_MASK          8'h3F
`define LINEAR_RW_MASK             8'h3F

`endif

// ===== design/rail_ctrl_pkg.sv
/*
 * types shared by the rail control register bank.
 * assumes the defines header sits in the include path.
 */
`default_nettype none
package rail_ctrl_pkg;
    `include "rail_ctrl_defines.svh"

    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic       rail_on;
        logic       use_sleep;
        logic       forced_pwm;
    } rail_drive_s;

    typedef enum logic {
        PIN_SEL_SLEEP1,
        PIN_SEL_SLEEP2
    } sleep_pin_e;
endpackage
`default_nettype wire

// ===== design/rail_drive.sv
/*
 * one rail: turns its control byte and pin states into registered drive.
 * assumes pin levels synchronous to clk; the sleep pin is chosen by a
 * factory strap parameter, never by software.
 */
`include "rail_ctrl_defines.svh"
`default_nettype none
module rail_drive #(
    parameter rail_ctrl_pkg::sleep_pin_e SLEEP_PIN   =
        rail_ctrl_pkg::PIN_SEL_SLEEP1,
    parameter bit                        HAS_MODE    = 1'b1
) (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst,
    // control
    input  wire logic [7:0]                 ctrl,
    input  wire logic                       pin_enable,
    input  wire logic                       ctrl_in3_sleep_pin1,
    input  wire logic                       ctrl_in6_sleep_pin2,
    // drive
    output rail_ctrl_pkg::rail_drive_s      drive
);
    import rail_ctrl_pkg::*;

    rail_drive_s drive_r;
    rail_drive_s drive_nxt;
    logic        sleep_pin;

    always_comb begin
        // fixed pin choice keeps software out of the sleep path
        sleep_pin = (SLEEP_PIN == PIN_SEL_SLEEP1) ?
                    ctrl_in3_sleep_pin1 : ctrl_in6_sleep_pin2;
        // software off beats every control input pin
        drive_nxt.rail_on = ctrl[`FLD_RAIL_ON] & pin_enable;
        // only 11 picks the sleep voltage; reserved codes act as normal
        drive_nxt.use_sleep =
            (ctrl[`FLD_SLEEP_SEL_HI:`FLD_SLEEP_SEL_LO] == `SLEEP_SEL_PIN)
            && !sleep_pin;
        drive_nxt.forced_pwm = HAS_MODE ?
            ctrl[`FLD_OP_MODE] : 1'b0;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            drive_r <= '0;
        end else begin
            drive_r <= drive_nxt;
        end
    end

    assign drive = drive_r;

    a_off_wins: assert property (@(posedge clk) disable iff (rst)
        !ctrl[`FLD_RAIL_ON] |=> !drive_r.rail_on)
        else $error("rail on while software off");
    a_sleep_sel: assert property (@(posedge clk) disable iff (rst)
        (ctrl[`FLD_SLEEP_SEL_HI:`FLD_SLEEP_SEL_LO] == `SLEEP_SEL_NORMAL)
        |=> !drive_r.use_sleep)
        else $error("sleep voltage used with selection 00");
    a_sleep_pin: assert property (@(posedge clk) disable iff (rst)
        (ctrl[`FLD_SLEEP_SEL_HI:`FLD_SLEEP_SEL_LO] == `SLEEP_SEL_PIN
         && !sleep_pin) |=> drive_r.use_sleep)
        else $error("sleep voltage missed with pin low");
endmodule // rail_drive
`default_nettype wire

// ===== design/rail_control_registers.sv
/*
 * control registers of two converters and one linear regulator, reached
 * through the serial control port's internal byte strobes.
 * assumes the port delivers one-cycle read/write strobes with address and
 * data synchronous to clk, and that it samples rdata one cycle after read.
 */
// Function
// - sleep field 00 keeps normal voltage; 11 uses sleep voltage when pin low
// - each rail's sleep pin is factory fixed, input three or input six
// - bit 0 low turns rail off whatever the six control inputs say
// - first converter bit 1 high means forced pwm; 0 reserved
// - second converter bit 1: 0 automatic, 1 forced pwm
`include "rail_ctrl_defines.svh"
`default_nettype none
module rail_control_registers #(
    parameter rail_ctrl_pkg::sleep_pin_e CONV_A_PIN =
        rail_ctrl_pkg::PIN_SEL_SLEEP1,
    parameter rail_ctrl_pkg::sleep_pin_e CONV_B_PIN =
        rail_ctrl_pkg::PIN_SEL_SLEEP1,
    parameter rail_ctrl_pkg::sleep_pin_e LIN_A_PIN  =
        rail_ctrl_pkg::PIN_SEL_SLEEP2
) (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    // serial control port side
    input wire rail_ctrl_pkg::reg_req_s req,
    output logic [7:0]                  rdata,
    output logic                        rvalid,
    // pins: six control inputs, bit 2 and bit 5 double as sleep pins
    input  wire logic [5:0]             rail_control_inputs,
    input  wire logic [2:0]             pin_enable,
    // rail drive
    output rail_ctrl_pkg::rail_drive_s  converter_a,
    output rail_ctrl_pkg::rail_drive_s  converter_b,
    output rail_ctrl_pkg::rail_drive_s  linear_reg_a
);
    import rail_ctrl_pkg::*;

    logic [7:0] conv_a_r, conv_a_nxt;
    logic [7:0] conv_b_r, conv_b_nxt;
    logic [7:0] lin_a_r,  lin_a_nxt;
    logic [7:0] rdata_r,  rdata_nxt;
    logic       rvalid_r, rvalid_nxt;
    logic       ctrl_in3_sleep_pin1;
    logic       ctrl_in6_sleep_pin2;

    assign ctrl_in3_sleep_pin1 = rail_control_inputs[2];
    assign ctrl_in6_sleep_pin2 = rail_control_inputs[5];

    always_comb begin
        conv_a_nxt = conv_a_r;
        conv_b_nxt = conv_b_r;
        lin_a_nxt  = lin_a_r;
        // reserved bits are stored as written; the masks drop 7:6 only
        if (req.write) begin
            case (req.addr)
                `ADDR_CONVERTER_A_CONTROL:
                    conv_a_nxt = req.wdata & `CONVERTER_RW_MASK;
                `ADDR_CONVERTER_B_CONTROL:
                    conv_b_nxt = req.wdata & `CONVERTER_RW_MASK;
                `ADDR_LINEAR_REG_A_CONTROL:
                    lin_a_nxt = req.wdata & `LINEAR_RW_MASK;
                default: ;
            endcase
        end
        rvalid_nxt = req.read;
        rdata_nxt  = 8'h00;
        if (req.read) begin
            case (req.addr)
                `ADDR_CONVERTER_A_CONTROL:  rdata_nxt = conv_a_r;
                `ADDR_CONVERTER_B_CONTROL:  rdata_nxt = conv_b_r;
                `ADDR_LINEAR_REG_A_CONTROL: rdata_nxt = lin_a_r;
                default:                    rdata_nxt = 8'h00;
            endcase
        end
    end

    // reset values: rails off, normal voltage, reserved patterns in place
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            conv_a_r <= `CONVERTER_RESET;
            conv_b_r <= `CONVERTER_RESET;
            lin_a_r  <= `LINEAR_RESET;
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            conv_a_r <= conv_a_nxt;
            conv_b_r <= conv_b_nxt;
            lin_a_r  <= lin_a_nxt;
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    assign rdata  = rdata_r;
    assign rvalid = rvalid_r;

    rail_drive #(
        .SLEEP_PIN (CONV_A_PIN),
        .HAS_MODE  (1'b1)
    ) u_conv_a (
        .clk                 (clk),
        .rst                 (rst),
        .ctrl                (conv_a_r),
        .pin_enable          (pin_enable[0]),
        .ctrl_in3_sleep_pin1 (ctrl_in3_sleep_pin1),
        .ctrl_in6_sleep_pin2 (ctrl_in6_sleep_pin2),
        .drive               (converter_a)
    );

    rail_drive #(
        .SLEEP_PIN (CONV_B_PIN),
        .HAS_MODE  (1'b1)
    ) u_conv_b (
        .clk                 (clk),
        .rst                 (rst),
        .ctrl                (conv_b_r),
        .pin_enable          (pin_enable[1]),
        .ctrl_in3_sleep_pin1 (ctrl_in3_sleep_pin1),
        .ctrl_in6_sleep_pin2 (ctrl_in6_sleep_pin2),
        .drive               (converter_b)
    );

    // the linear regulator has no mode bit; its bit 1 is reserved
    rail_drive #(
        .SLEEP_PIN (LIN_A_PIN),
        .HAS_MODE  (1'b0)
    ) u_lin_a (
        .clk                 (clk),
        .rst                 (rst),
        .ctrl                (lin_a_r),
        .pin_enable          (pin_enable[2]),
        .ctrl_in3_sleep_pin1 (ctrl_in3_sleep_pin1),
        .ctrl_in6_sleep_pin2 (ctrl_in6_sleep_pin2),
        .drive               (linear_reg_a)
    );

    a_top_bits_zero: assert property (@(posedge clk) disable iff (rst)
        rvalid_r |-> rdata_r[7:6] == 2'h0)
        else $error("bits 7:6 read nonzero");
    a_write_stored: assert property (@(posedge clk) disable iff (rst)
        (req.write && req.addr == `ADDR_CONVERTER_B_CONTROL)
        |=> conv_b_r == ($past(req.wdata) & `CONVERTER_RW_MASK))
        else $error("converter b write not stored");
    a_mode_b: assert property (@(posedge clk) disable iff (rst)
        (req.write && req.addr == `ADDR_CONVERTER_B_CONTROL)
        |-> ##2 converter_b.forced_pwm == $past(req.wdata[1], 2))
        else $error("converter b mode not followed");
    a_mode_a: assert property (@(posedge clk) disable iff (rst)
        (req.write && req.addr == `ADDR_CONVERTER_A_CONTROL
         && req.wdata[1]) |-> ##2 converter_a.forced_pwm)
        else $error("converter a not forced pwm");
    a_lin_off: assert property (@(posedge clk) disable iff (rst)
        (req.write && req.addr == `ADDR_LINEAR_REG_A_CONTROL
         && !req.wdata[0]) |-> ##2 !linear_reg_a.rail_on)
        else $error("linear regulator on after off write");
    a_read_echo: assert property (@(posedge clk) disable iff (rst)
        (req.read && !req.write && req.addr == `ADDR_LINEAR_REG_A_CONTROL)
        |=> rvalid_r && rdata_r == $past(lin_a_r))
        else $error("linear register read mismatch");

    // every read strobe gets exactly one answer, the next cycle
    a_read_answer: assert property (@(posedge clk) disable iff (rst)
        req.read |=> rvalid_r)
        else $error("read strobe without answer");
    a_no_stray_answer: assert property (@(posedge clk) disable iff (rst)
        !req.read |=> !rvalid_r)
        else $error("answer without read strobe");
    a_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
        (req.read && req.addr != `ADDR_CONVERTER_A_CONTROL
         && req.addr != `ADDR_CONVERTER_B_CONTROL
         && req.addr != `ADDR_LINEAR_REG_A_CONTROL)
        |=> rdata_r == 8'h00)
        else $error("unmapped read returned data");
    a_read_a_echo: assert property (@(posedge clk) disable iff (rst)
        (req.read && !req.write && req.addr == `ADDR_CONVERTER_A_CONTROL)
        |=> rdata_r == $past(conv_a_r))
        else $error("converter a read mismatch");
    a_read_b_echo: assert property (@(posedge clk) disable iff (rst)
        (req.read && !req.write && req.addr == `ADDR_CONVERTER_B_CONTROL)
        |=> rdata_r == $past(conv_b_r))
        else $error("converter b read mismatch");

    // writes land next cycle minus bits 7:6; nothing else moves them
    a_store_a: assert property (@(posedge clk) disable iff (rst)
        (req.write && req.addr == `ADDR_CONVERTER_A_CONTROL)
        |=> conv_a_r == ($past(req.wdata) & `CONVERTER_RW_MASK))
        else $error("converter a write not stored");
    a_store_lin: assert property (@(posedge clk) disable iff (rst)
        (req.write && req.addr == `ADDR_LINEAR_REG_A_CONTROL)
        |=> lin_a_r == ($past(req.wdata) & `LINEAR_RW_MASK))
        else $error("linear regulator write not stored");
    a_regs_held: assert property (@(posedge clk) disable iff (rst)
        (!req.write || (req.addr != `ADDR_CONVERTER_A_CONTROL
                        && req.addr != `ADDR_CONVERTER_B_CONTROL
                        && req.addr != `ADDR_LINEAR_REG_A_CONTROL))
        |=> $stable(conv_a_r) && $stable(conv_b_r) && $stable(lin_a_r))
        else $error("register changed without its write");

    // software off and pin off each keep the rail off
    a_conv_a_off: assert property (@(posedge clk) disable iff (rst)
        (req.write && req.addr == `ADDR_CONVERTER_A_CONTROL
         && !req.wdata[`FLD_RAIL_ON]) |-> ##2 !converter_a.rail_on)
        else $error("converter a on after off write");
    a_conv_b_off: assert property (@(posedge clk) disable iff (rst)
        (req.write && req.addr == `ADDR_CONVERTER_B_CONTROL
         && !req.wdata[`FLD_RAIL_ON]) |-> ##2 !converter_b.rail_on)
        else $error("converter b on after off write");
    a_pins_off: assert property (@(posedge clk) disable iff (rst)
        (pin_enable == 3'h0) |=> (!converter_a.rail_on
         && !converter_b.rail_on && !linear_reg_a.rail_on))
        else $error("rail on with every pin enable low");

    // only the strapped pin may call for the sleep voltage
    a_strap_conv_a: assert property (@(posedge clk) disable iff (rst)
        (conv_a_r[`FLD_SLEEP_SEL_HI:`FLD_SLEEP_SEL_LO] == `SLEEP_SEL_PIN
         && ((CONV_A_PIN == PIN_SEL_SLEEP1) ? ctrl_in3_sleep_pin1
                                            : ctrl_in6_sleep_pin2))
        |=> !converter_a.use_sleep)
        else $error("converter a sleeps with its pin high");
    a_strap_conv_b: assert property (@(posedge clk) disable iff (rst)
        (conv_b_r[`FLD_SLEEP_SEL_HI:`FLD_SLEEP_SEL_LO] == `SLEEP_SEL_PIN
         && ((CONV_B_PIN == PIN_SEL_SLEEP1) ? ctrl_in3_sleep_pin1
                                            : ctrl_in6_sleep_pin2))
        |=> !converter_b.use_sleep)
        else $error("converter b sleeps with its pin high");
    a_strap_lin: assert property (@(posedge clk) disable iff (rst)
        (lin_a_r[`FLD_SLEEP_SEL_HI:`FLD_SLEEP_SEL_LO] == `SLEEP_SEL_PIN
         && ((LIN_A_PIN == PIN_SEL_SLEEP1) ? ctrl_in3_sleep_pin1
                                           : ctrl_in6_sleep_pin2))
        |=> !linear_reg_a.use_sleep)
        else $error("linear regulator sleeps with pin high");

    // mode bits reach the converters a cycle after the register
    a_mode_a_reg: assert property (@(posedge clk) disable iff (rst)
        conv_a_r[`FLD_OP_MODE] |=> converter_a.forced_pwm)
        else $error("converter a left forced pwm");
    a_mode_b_reg: assert property (@(posedge clk) disable iff (rst)
        !conv_b_r[`FLD_OP_MODE] |=> !converter_b.forced_pwm)
        else $error("converter b not in automatic mode");
endmodule // rail_control_registers
`default_nettype wire

// ===== dv/rail_control_registers_tb_top.sv
/*
 * self-checking bench for the rail control register bank: byte strobe
 * reads and writes, readback, pin-driven rail drive outputs.
 * assumes the default sleep pin straps: both converters on pin 1, linear
 * regulator on pin 2.
 */
`default_nettype none
module rail_control_registers_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rail_ctrl_pkg::*;
    `include "rail_ctrl_defines.svh"

    localparam int LIMIT = 3000;

    logic        clk;
    logic        rst;
    reg_req_s    req;
    logic [7:0]  rdata;
    logic        rvalid;
    logic [5:0]  rail_control_inputs;
    logic [2:0]  pin_enable;
    rail_drive_s converter_a;
    rail_drive_s converter_b;
    rail_drive_s linear_reg_a;
    int          n_mismatch = 0;
    int          n_compared = 0;
    int          cycles = 0;

    rail_control_registers DUT (
        .clk                 (clk),
        .rst                 (rst),
        .req                 (req),
        .rdata               (rdata),
        .rvalid              (rvalid),
        .rail_control_inputs (rail_control_inputs),
        .pin_enable          (pin_enable),
        .converter_a         (converter_a),
        .converter_b         (converter_b),
        .linear_reg_a        (linear_reg_a)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // strobe is held one cycle and dropped at the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        req <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        req <= '0;
        #1;
        chk({7'h00, rvalid}, 8'h01);
        chk(rdata, exp);
    endtask

    // a hang counts as a mismatch and still reaches the verdict
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_mismatch++;
            give_verdict();
        end
    end

    initial begin
        logic [1:0] code;
        logic       on;
        logic       m;
        logic       pins;
        logic [2:0] pe;
        req = '0;
        rail_control_inputs = 6'h3F;
        pin_enable = 3'h0;
        rst = 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(`ADDR_CONVERTER_A_CONTROL, 8'h0C);
        rd(`ADDR_CONVERTER_B_CONTROL, 8'h0C);
        rd(`ADDR_LINEAR_REG_A_CONTROL, 8'h0C);
        chk({5'h00, converter_a}, 8'h00);
        $display("test reset_values done");
        // top bits written as ones must read back as zero
        wr(`ADDR_CONVERTER_A_CONTROL, 8'hFF);
        wr(`ADDR_CONVERTER_B_CONTROL, 8'hFF);
        wr(`ADDR_LINEAR_REG_A_CONTROL, 8'hCD);
        wr(8'h29, 8'hFF);
        rd(`ADDR_CONVERTER_A_CONTROL, 8'h3F);
        rd(`ADDR_CONVERTER_B_CONTROL, 8'h3F);
        rd(`ADDR_LINEAR_REG_A_CONTROL, 8'h0D);
        rd(8'h29, 8'h00);
        $display("test read_only_bits done");
        // only legal sleep codes and reserved patterns are ever written
        for (int i = 0; i < 32; i++) begin
            code = i[0] ? 2'h3 : 2'h0;
            on = i[1];
            m = i[2];
            pins = i[3];
            pe = i[4] ? 3'h7 : 3'h2;
            @(posedge clk);
            pin_enable <= pe;
            rail_control_inputs <= pins ? 6'h1F : 6'h3B;
            wr(`ADDR_CONVERTER_A_CONTROL, {2'h0, code, 3'h7, on});
            wr(`ADDR_CONVERTER_B_CONTROL, {2'h0, code, 2'h3, m, on});
            wr(`ADDR_LINEAR_REG_A_CONTROL, {2'h0, code, 3'h6, on});
            rd(`ADDR_CONVERTER_B_CONTROL, {2'h0, code, 2'h3, m, on});
            chk({5'h00, converter_a},
                {5'h00, on & pe[0], code[0] & ~pins, 1'b1});
            chk({5'h00, converter_b},
                {5'h00, on & pe[1], code[0] & ~pins, m});
            chk({5'h00, linear_reg_a},
                {5'h00, on & pe[2], code[0] & pins, 1'b0});
        end
        $display("test rail_drive done");
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        rd(`ADDR_CONVERTER_B_CONTROL, 8'h0C);
        chk({5'h00, linear_reg_a}, 8'h00);
        $display("test second_reset done");
        give_verdict();
    end
endmodule // rail_control_registers_tb_top
`default_nettype wire
